// *** src/dlx_addr_step.sv ***
`timescale 1ns/100ps
`include "dlx_defines.svh"

// next-address unit for one channel side
module dlx_addr_step (
	input wire logic [31:0] cur_addr,
	input wire logic [31:0] start_addr,
	input wire logic [2:0] update_code,
	input wire logic [1:0] width_code,
	input wire logic inner_reload,
	output logic [31:0] next_addr
);
	wire [31:0] item_bytes;
	wire [31:0] step;
	wire rewind_on;

	// item size in bytes from width code
	assign item_bytes = (width_code == `DLX_TW_HALF) ? 32'h0000_0002 :
		(width_code == `DLX_TW_WORD) ? 32'h0000_0004 : 32'h0000_0001;
	// step per transfer; code 5 holds the address
	assign step = (update_code == `DLX_AC_INC2 ||
		update_code == `DLX_AC_INC2_RW) ? (item_bytes << 1) :
		(update_code == `DLX_AC_INC4) ? (item_bytes << 2) :
		(update_code == `DLX_AC_FIX) ? `DLX_ZERO32 : item_bytes;
	assign rewind_on = (update_code == `DLX_AC_INC1_RW) ||
		(update_code == `DLX_AC_INC2_RW) ||
		(update_code == `DLX_AC_DEC1_RW);
	// rewind codes go back to start on inner reload, else step on
	assign next_addr = (inner_reload && rewind_on) ? start_addr :
		(update_code == `DLX_AC_DEC1 || update_code == `DLX_AC_DEC1_RW) ?
		cur_addr - step : cur_addr + step;
endmodule

// *** src/dlx_core.sv ***
`timescale 1ns/100ps
`include "dlx_defines.svh"

// Functional notes
// - item width is 8, 16 or 32 bits from the two-bit width code
// - a record moves width times inner initial times outer remaining
// - mode 0: each trigger runs inner-initial transfers, then chains or waits
// - mode 0: record ends after outer-remaining triggers
// - mode 1: each trigger runs exactly one transfer, then chains or waits
// - mode 1: record ends after inner times outer triggers
// - mode 0: controller loads inner remaining from inner initial itself
// - source start address from word 2, destination from word 3
// - source and destination update codes are independent word 0 fields
// - codes 000/001 step one width, 010/011 two, 100 four; odd rewind
// - 101 holds, 110/111 decrement one width, only 111 rewinds
// - inner remaining counts down each transfer, reloads after inner initial
// - outer remaining counts down on each inner reload
// - with rewind the address returns to its start on inner reload
// - without rewind the address keeps advancing across reloads
// - source and destination each step by their own amount
// - unfinished record: counts and addresses written back, resume later
// - finished record runs the close process unless suppressed
module dlx_core (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic start_trig,
	input wire logic chain_trig,
	input wire logic [31:0] record_word0,
	input wire logic [31:0] record_word1,
	input wire logic [31:0] record_word2,
	input wire logic [31:0] record_word3,
	input wire logic [31:0] bus_rdata,
	input wire logic bus_ready,
	output logic busy,
	output logic bus_read,
	output logic bus_write,
	output logic [31:0] bus_addr,
	output logic [1:0] bus_size,
	output logic [31:0] bus_wdata,
	output logic wb_valid,
	output logic [31:0] wb_word1,
	output logic [31:0] wb_word2,
	output logic [31:0] wb_word3,
	output logic record_done,
	output logic close_req
);
	import dlx_pkg::*;

	dlx_state_t state;
	dlx_state_t next_state;
	logic loaded;
	logic mode;
	logic [1:0] width;
	logic [2:0] src_code;
	logic [2:0] dst_code;
	logic no_close;
	logic [16:0] inner_init;
	logic [16:0] inner_rem;
	logic [16:0] outer_rem;
	logic [31:0] src_addr;
	logic [31:0] dst_addr;
	logic [31:0] src_start;
	logic [31:0] dst_start;
	logic [31:0] data_hold;

	wire [16:0] w1_iin;
	wire [16:0] w1_irm;
	wire [16:0] w1_orm;
	wire inner_last;
	wire outer_last;
	wire xfer_done;
	wire burst_end;
	wire [31:0] next_src;
	wire [31:0] next_dst;
	wire [16:0] next_inner;
	wire [16:0] next_outer;
	wire trig;
	wire rec_load;
	wire [31:0] first_src;
	wire [1:0] next_width;

	// zero in the outer count field means the full 65536
	function automatic logic [16:0] count_of(input logic [15:0] f);
		count_of = (f == 16'h0000) ? 17'h1_0000 : {1'b0, f};
	endfunction

	// zero in an eight-bit inner count field means the full 256
	function automatic logic [16:0] inner_of(input logic [7:0] f);
		inner_of = (f == 8'h00) ? `DLX_INNER_FULL : {9'h000, f};
	endfunction

	// record word 1 field decode
	assign w1_iin = inner_of(record_word1[`DLX_W1_IIN_HI:`DLX_W1_IIN_LO]);
	assign w1_irm = inner_of(record_word1[`DLX_W1_IRM_HI:`DLX_W1_IRM_LO]);
	assign w1_orm = count_of(record_word1[`DLX_W1_ORM_HI:`DLX_W1_ORM_LO]);
	assign trig = start_trig | chain_trig;

	// a fresh record loads this cycle; its fields bypass the registers
	assign rec_load = (state == DLX_IDLE) && trig && !loaded;
	assign first_src = rec_load ? record_word2 : src_addr;
	assign next_width = rec_load ?
		record_word0[`DLX_W0_TW_HI:`DLX_W0_TW_LO] : width;

	// transfer bookkeeping
	assign xfer_done = (state == DLX_WRITE) && bus_ready;
	assign inner_last = (inner_rem == `DLX_ONE17); // reload point
	assign outer_last = (outer_rem == `DLX_ONE17);
	// mode 1 ends after one item, mode 0 after a full inner pass
	assign burst_end = mode | inner_last;
	assign next_inner = inner_last ? inner_init : inner_rem - `DLX_ONE17;
	assign next_outer = inner_last ? outer_rem - `DLX_ONE17 : outer_rem;

	// per-side address update, independent codes
	dlx_addr_step u_src (
		.cur_addr(src_addr),
		.start_addr(src_start),
		.update_code(src_code),
		.width_code(width),
		.inner_reload(inner_last),
		.next_addr(next_src)
	);
	dlx_addr_step u_dst (
		.cur_addr(dst_addr),
		.start_addr(dst_start),
		.update_code(dst_code),
		.width_code(width),
		.inner_reload(inner_last),
		.next_addr(next_dst)
	);

	// sequencer: read item, write item, then save or close
	always_comb begin
		next_state = state;
		case (state)
			DLX_IDLE: begin
				if (trig) begin
					next_state = DLX_READ;
				end
			end
			DLX_READ: begin
				if (bus_ready) begin
					next_state = DLX_WRITE;
				end
			end
			DLX_WRITE: begin
				if (bus_ready) begin
					if (inner_last && outer_last) begin
						next_state = DLX_CLOSE; // whole record moved
					end else if (burst_end) begin
						next_state = DLX_SAVE;
					end else begin
						next_state = DLX_READ;
					end
				end
			end
			DLX_SAVE: next_state = DLX_IDLE;
			DLX_CLOSE: next_state = DLX_IDLE;
			default: next_state = DLX_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state <= DLX_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// record load on trigger while not already resident
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			loaded <= 1'b0;
		end else if (state == DLX_CLOSE) begin
			loaded <= 1'b0;
		end else if (state == DLX_IDLE && trig) begin
			loaded <= 1'b1;
		end
	end

	// configuration capture from word 0
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			mode <= 1'b0;
			width <= `DLX_TW_BYTE;
			src_code <= `DLX_AC_INC1;
			dst_code <= `DLX_AC_INC1;
			no_close <= 1'b0;
		end else if (state == DLX_IDLE && trig && !loaded) begin
			mode <= record_word0[`DLX_W0_MODE];
			width <= record_word0[`DLX_W0_TW_HI:`DLX_W0_TW_LO];
			src_code <= record_word0[`DLX_W0_SAC_HI:`DLX_W0_SAC_LO];
			dst_code <= record_word0[`DLX_W0_DAC_HI:`DLX_W0_DAC_LO];
			no_close <= record_word0[`DLX_W0_NOCLOSE];
		end
	end

	// counters: mode 0 ignores written inner remaining
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			inner_init <= `DLX_ZERO17;
			inner_rem <= `DLX_ZERO17;
			outer_rem <= `DLX_ZERO17;
		end else if (state == DLX_IDLE && trig && !loaded) begin
			inner_init <= w1_iin;
			inner_rem <= record_word0[`DLX_W0_MODE] ? w1_irm : w1_iin;
			outer_rem <= w1_orm;
		end else if (xfer_done) begin
			inner_rem <= next_inner;
			outer_rem <= next_outer;
		end
	end

	// addresses from words 2 and 3, stepped after each write
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			src_addr <= `DLX_ZERO32;
			dst_addr <= `DLX_ZERO32;
			src_start <= `DLX_ZERO32;
			dst_start <= `DLX_ZERO32;
		end else if (state == DLX_IDLE && trig && !loaded) begin
			src_addr <= record_word2;
			dst_addr <= record_word3;
			src_start <= record_word2;
			dst_start <= record_word3;
		end else if (xfer_done) begin
			src_addr <= next_src;
			dst_addr <= next_dst;
		end
	end

	// data item captured between read and write
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			data_hold <= `DLX_ZERO32;
		end else if (state == DLX_READ && bus_ready) begin
			data_hold <= bus_rdata;
		end
	end

	// bus request outputs, registered
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			bus_read <= 1'b0;
			bus_write <= 1'b0;
			bus_addr <= `DLX_ZERO32;
			bus_size <= `DLX_TW_BYTE;
			bus_wdata <= `DLX_ZERO32;
			busy <= 1'b0;
		end else begin
			bus_read <= (next_state == DLX_READ);
			bus_write <= (next_state == DLX_WRITE);
			busy <= (next_state != DLX_IDLE);
			bus_size <= next_width;
			if (next_state == DLX_READ) begin
				bus_addr <= (state == DLX_WRITE) ? next_src : first_src;
			end else if (next_state == DLX_WRITE) begin
				bus_addr <= dst_addr;
				// read data stands only with ready; later cycles use the copy
				bus_wdata <= (state == DLX_READ) ? bus_rdata : data_hold;
			end
		end
	end

	// write-back of progress and record close signalling
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			wb_valid <= 1'b0;
			wb_word1 <= `DLX_ZERO32;
			wb_word2 <= `DLX_ZERO32;
			wb_word3 <= `DLX_ZERO32;
			record_done <= 1'b0;
			close_req <= 1'b0;
		end else begin
			wb_valid <= (state == DLX_SAVE);
			record_done <= (state == DLX_CLOSE);
			close_req <= (state == DLX_CLOSE) && !no_close;
			if (state == DLX_SAVE) begin
				wb_word1 <= {outer_rem[15:0], inner_init[7:0],
					inner_rem[7:0]};
				wb_word2 <= src_addr;
				wb_word3 <= dst_addr;
			end
		end
	end
endmodule

// *** src/dlx_defines.svh ***
`ifndef DLX_DEFINES_SVH
`define DLX_DEFINES_SVH

// transfer width codes
`define DLX_TW_BYTE 2'b00
`define DLX_TW_HALF 2'b01
`define DLX_TW_WORD 2'b10

// address update codes
`define DLX_AC_INC1 3'b000
`define DLX_AC_INC1_RW 3'b001
`define DLX_AC_INC2 3'b010
`define DLX_AC_INC2_RW 3'b011
`define DLX_AC_INC4 3'b100
`define DLX_AC_FIX 3'b101
`define DLX_AC_DEC1 3'b110
`define DLX_AC_DEC1_RW 3'b111

// record word 0 field positions
`define DLX_W0_MODE 0
`define DLX_W0_TW_LO 1
`define DLX_W0_TW_HI 2
`define DLX_W0_SAC_LO 3
`define DLX_W0_SAC_HI 5
`define DLX_W0_DAC_LO 6
`define DLX_W0_DAC_HI 8
`define DLX_W0_NOCLOSE 9

// record word 1 field positions
`define DLX_W1_IRM_LO 0
`define DLX_W1_IRM_HI 7
`define DLX_W1_IIN_LO 8
`define DLX_W1_IIN_HI 15
`define DLX_W1_ORM_LO 16
`define DLX_W1_ORM_HI 31

// resets and counts
`define DLX_ZERO32 32'h0000_0000
`define DLX_ZERO17 17'h0_0000
`define DLX_ONE17 17'h0_0001
`define DLX_INNER_FULL 17'h0_0100

`endif

// *** src/dlx_pkg.sv ***
package dlx_pkg;
	typedef enum logic [2:0] {
		DLX_IDLE,
		DLX_READ,
		DLX_WRITE,
		DLX_SAVE,
		DLX_CLOSE
	} dlx_state_t;

	typedef logic [31:0] dlx_addr_t;
	typedef logic [16:0] dlx_count_t;
endpackage

// *** test/dlx_core_properties.sv ***
`timescale 1ns/100ps
// port-level checks of the transfer core
module dlx_core_properties (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic start_trig,
	input wire logic chain_trig,
	input wire logic [31:0] record_word0,
	input wire logic [31:0] bus_rdata,
	input wire logic bus_ready,
	input wire logic busy,
	input wire logic bus_read,
	input wire logic bus_write,
	input wire logic [31:0] bus_addr,
	input wire logic [1:0] bus_size,
	input wire logic [31:0] bus_wdata,
	input wire logic record_done,
	input wire logic close_req
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	// trigger handling and request holding
	AST_TRIG_READ: assert property (
		!busy && (start_trig || chain_trig) |=> bus_read)
		else $error("no read after trigger");
	AST_RD_HOLD: assert property (
		bus_read && !bus_ready |=> bus_read && $stable(bus_addr))
		else $error("read dropped early");
	AST_WR_HOLD: assert property (
		bus_write && !bus_ready |=> bus_write && $stable(bus_wdata))
		else $error("write dropped early");
	AST_PASS: assert property (
		bus_read && bus_ready |=> bus_write && bus_wdata == $past(bus_rdata))
		else $error("read data not written");

	// width, alignment, mode 1 pacing, close
	AST_SIZE: assert property (
		bus_read || bus_write |-> bus_size == record_word0[2:1])
		else $error("wrong item size");
	AST_ALIGN: assert property (
		bus_read || bus_write |->
		(bus_addr & ((32'h0000_0001 << bus_size) - 32'h0000_0001)) == 0)
		else $error("unaligned access");
	AST_ONE_ITEM: assert property (
		record_word0[0] && bus_write && bus_ready |=> !bus_read [*2])
		else $error("second item in one trigger");
	AST_CLOSE: assert property (
		close_req |-> record_done && !record_word0[9])
		else $error("close without done");
endmodule

bind dlx_core dlx_core_properties chk (.*);

// *** test/dlx_core_tb.sv ***
`timescale 1ns/100ps
module dlx_core_tb;
	logic mclk = 0, rst_b = 0, start_trig = 0, chain_trig = 0, slow = 0;
	logic [31:0] record_word0 = 0, record_word1 = 0;
	logic [31:0] record_word2 = 0, record_word3 = 0;
	logic [31:0] bus_rdata, bus_addr, bus_wdata, wb_word1, wb_word2, wb_word3;
	logic bus_ready, busy, bus_read, bus_write, wb_valid, record_done;
	logic close_req;
	logic [1:0] bus_size, cur_tw;
	logic [63:0] q[$];
	int errors = 0, n_tests = 0, n_done, n_close, n_wb, k;
	int n_items = 0, cur_iin = 1, cur_orm = 1;

	always #2 mclk = ~mclk;
	dlx_core dut (.*);
	dlx_mem_model mem (.*);

	task chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (e !== g) begin
			errors++;
			$display("BAD %s exp %h got %h", what, e, g);
		end
	endtask

	task summarize;
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// expected address after one item, rewind on the inner reload
	function logic [31:0] adv(logic [31:0] a, logic [2:0] c, logic [1:0] tw,
		bit last, logic [31:0] st);
		logic [31:0] w;
		w = 32'h0000_0001 << tw;
		if (last && c[0] && c != 3'b101)
			return st;
		case (c)
			3'b000, 3'b001: return a + w;
			3'b010, 3'b011: return a + 2 * w;
			3'b100: return a + 4 * w;
			3'b101: return a;
			default: return a - w;
		endcase
	endfunction

	// one trigger, then a second one while busy that must be ignored
	task trig(input bit ch);
		int i;
		start_trig = !ch;
		chain_trig = ch;
		#4 start_trig = 0;
		chain_trig = 0;
		#4 start_trig = 1;
		#4 start_trig = 0;
		for (i = 0; i < 5000 && busy !== 1'b0; i++)
			#4;
		if (i == 5000) begin
			errors++;
			summarize();
		end
		#16;
	endtask

	// build a record, note every item, fire the triggers
	task run_rec(input bit m, input int tw, sc, dc, inner_loop_initial, outer_loop_remaining, input bit nc);
		logic [31:0] s, d;
		int i, o, nt;
		record_word2 = $urandom & 32'hffff_fff0;
		record_word3 = $urandom & 32'hffff_fff0;
		record_word0 = {22'h0, nc, dc[2:0], sc[2:0], tw[1:0], m};
		record_word1 = {outer_loop_remaining[15:0], inner_loop_initial[7:0], m ? inner_loop_initial[7:0] : 8'h5a};
		slow = $urandom % 2;
		cur_tw = tw[1:0];
		s = record_word2;
		d = record_word3;
		for (o = 0; o < outer_loop_remaining; o++)
			for (i = 0; i < inner_loop_initial; i++) begin
				q.push_back({d, s ^ 32'ha5a5_5a5a});
				s = adv(s, sc[2:0], tw[1:0], i == inner_loop_initial - 1, record_word2);
				d = adv(d, dc[2:0], tw[1:0], i == inner_loop_initial - 1, record_word3);
			end
		n_done = 0;
		n_close = 0;
		n_wb = 0;
		n_items = 0;
		cur_iin = inner_loop_initial;
		cur_orm = outer_loop_remaining;
		nt = m ? inner_loop_initial * outer_loop_remaining : outer_loop_remaining;
		for (i = 0; i < nt; i++)
			trig(i[0]);
		chk("records", 1, n_done);
		chk("closes", nc ? 0 : 1, n_close);
		chk("saves", nt - 1, n_wb);
		chk("items left", 0, q.size());
	endtask

	// compare each accepted write with the oldest note
	always @(posedge mclk) begin
		if (bus_write === 1'b1 && bus_ready === 1'b1) begin
			if (q.size() == 0)
				chk("extra write", 0, 1);
			else begin
				chk("dst", q[0][63:32], bus_addr);
				chk("data", q[0][31:0], bus_wdata);
				void'(q.pop_front());
			end
			chk("size", {30'h0, cur_tw}, {30'h0, bus_size});
			n_items++;
		end
		// progress written back points at the next item still to move
		if (wb_valid === 1'b1 && q.size() > 0) begin
			chk("wb src", q[0][31:0] ^ 32'ha5a5_5a5a, wb_word2);
			chk("wb dst", q[0][63:32], wb_word3);
			chk("wb counts", {16'(cur_orm - n_items / cur_iin), 8'(cur_iin),
				8'(cur_iin - n_items % cur_iin)}, wb_word1);
		end
		n_done += (record_done === 1'b1);
		n_close += (close_req === 1'b1);
		n_wb += (wb_valid === 1'b1);
	end

	// every code, width and mode, a stride, a full inner count, then random
	initial begin
		k = $urandom(90345);
		#11 rst_b = 1;
		for (k = 0; k < 8; k++)
			run_rec(k[0], k % 3, k, 7 - k, 1 + k % 4, 1 + k % 3, k == 5);
		run_rec(0, 2, 2, 4, 3, 2, 0);
		run_rec(0, 0, 1, 6, 256, 2, 0);
		for (k = 0; k < 6; k++)
			run_rec($urandom % 2, $urandom % 3, $urandom % 8, $urandom % 8,
				1 + $urandom % 4, 1 + $urandom % 3, $urandom % 2);
		summarize();
	end
endmodule

// *** test/dlx_mem_model.sv ***
`timescale 1ns/100ps
// system bus memory: answers at once, or after a random wait when slow; data tracks the address
module dlx_mem_model (
	input wire logic mclk,
	input wire logic slow,
	input wire logic bus_read,
	input wire logic bus_write,
	input wire logic [31:0] bus_addr,
	output logic bus_ready,
	output logic [31:0] bus_rdata
);
	int w = 0;

	// ready for one cycle, read data is noise outside it
	always @(posedge mclk) begin
		#1;
		if (bus_ready === 1'b1)
			w = slow ? $urandom % 4 : 0;
		bus_ready = 0;
		if (bus_read || bus_write) begin
			if (w == 0)
				bus_ready = 1;
			else
				w--;
		end
		bus_rdata = bus_ready && bus_read ? bus_addr ^ 32'ha5a5_5a5a : $urandom;
	end
	initial bus_ready = 0;
endmodule
